// *** pc_stack_pkg.sv ***
// constants for program counter, return stack and indirect addressing
package pc_stack_pkg;
	localparam int PC_W        = 13;
	localparam int LOW_W       = 8;
	localparam int HIGH_W      = 5;
	localparam int JUMP_W      = 11;
	localparam int PAGE_W      = 2;
	localparam int STACK_DEPTH = 8;
	localparam int DADDR_W     = 9;
	localparam logic [PC_W-1:0]  PC_RESET      = 13'h0000;
	localparam logic [HIGH_W-1:0] LATCH_RESET  = 5'h00;
	localparam logic [LOW_W-1:0] PTR_RESET     = 8'h00;
	localparam logic [LOW_W-1:0] INDIRECT_ADDR = 8'h00;
	localparam logic [LOW_W-1:0] PC_LOW_ADDR   = 8'h02;
	localparam logic [LOW_W-1:0] FILE_PTR_ADDR = 8'h04;
	localparam logic [LOW_W-1:0] LATCH_ADDR    = 8'h0a;
	localparam logic [LOW_W-1:0] ZERO_BYTE     = 8'h00;
	localparam logic [LOW_W-1:0] ADDR_LOW_MASK = 8'h7f;
	localparam logic [PC_W-1:0]  PC_STEP       = 13'h0001;

	typedef enum logic [2:0] {
		PC_NEXT   = 3'b000,
		PC_HOLD   = 3'b001,
		PC_JUMP   = 3'b010,
		PC_RETURN = 3'b011,
		PC_VECTOR = 3'b100,
		PC_WRLOW  = 3'b101
	} pc_op_t;
endpackage

// *** return_stack_mem.sv ***
// eight-entry return address memory with registered read data
`timescale 1ns/1ps
module return_stack_mem
	import pc_stack_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH,
	parameter int WIDTH = PC_W,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             sys_clk,
	input  wire logic             arst_n,
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] store [DEPTH];

	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			store[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_data <= '0;
		end else begin
			rd_data <= store[rd_addr];
		end
	end
endmodule

// *** indirect_addr_unit.sv ***
// indirect access address redirection and self-reference guard
`timescale 1ns/1ps
module indirect_addr_unit
	import pc_stack_pkg::*;
(
	input  wire logic [LOW_W-1:0]   operand_addr,
	input  wire logic [LOW_W-1:0]   file_ptr,
	input  wire logic               indirect_bank_bit,
	output logic      [DADDR_W-1:0] eff_addr,
	output logic                    is_indirect,
	output logic                    self_ref
);
	logic bank_used;

	// bank bit unused in this variant
	assign bank_used   = 1'b0 & indirect_bank_bit;
	// both bank images of the port address redirect
	assign is_indirect = ((operand_addr & ADDR_LOW_MASK)
	                      == INDIRECT_ADDR);
	assign self_ref    = is_indirect && (file_ptr == INDIRECT_ADDR);
	// bank bit sits above the pointer byte
	assign eff_addr    = is_indirect ? {bank_used, file_ptr}
	                                 : {1'b0, operand_addr};
endmodule

// *** pc_stack_indirect_addr.sv ***
// program counter, return stack and indirect file access
`timescale 1ns/1ps

// Behaviour
// - thirteen bit counter, low byte read/write
// - upper bits loaded from holding latch and jump target, return stack or vector only
// - every reset clears program counter
// - low byte write loads latch bits 4:0
// - call or jump takes latch bits 4:3
// - eight entry thirteen bit return stack
// - stack pointer hidden from software
// - push on call and interrupt vector
// - pop on return, literal and interrupt exit
// - push and pop leave latch alone
// - stack wraps, overwriting oldest entry
// - no overflow or underflow indication
// - indirect port redirects through file pointer
// - self-referencing indirect read gives zero
// - self-referencing indirect write discarded
// - nine bit address: bank over pointer
// - bank bit unused, pointer only
module pc_stack_indirect_addr
	import pc_stack_pkg::*;
#(
	parameter logic [PC_W-1:0] VECTOR_ADDR = 13'h0004,
	parameter int              DEPTH       = STACK_DEPTH
) (
	input  wire logic               sys_clk,
	input  wire logic               arst_n,
	input  wire logic               soft_reset,
	input  wire logic               advance,
	input  wire logic               do_call,
	input  wire logic               do_jump,
	input  wire logic               do_return,
	input  wire logic               do_exit_literal,
	input  wire logic               do_interrupt_exit,
	input  wire logic               do_vector,
	input  wire logic [JUMP_W-1:0]  target_addr,
	input  wire logic               file_wr,
	input  wire logic               file_rd,
	input  wire logic [LOW_W-1:0]   operand_addr,
	input  wire logic [LOW_W-1:0]   file_wr_data,
	input  wire logic [LOW_W-1:0]   ram_rd_data,
	input  wire logic               indirect_bank_bit,
	output logic      [PC_W-1:0]    pc,
	output logic      [LOW_W-1:0]   file_rd_data,
	output logic                    ram_wr,
	output logic                    ram_rd,
	output logic      [DADDR_W-1:0] ram_addr,
	output logic      [LOW_W-1:0]   ram_wr_data,
	output logic                    pop_valid
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW-1:0] PTR_ONE = AW'(1);

	// ==========================================================
	// state
	logic [HIGH_W-1:0]  pc_high_holding_latch;
	logic [LOW_W-1:0]   file_pointer_reg;
	logic [AW-1:0]      stack_ptr;
	logic [PC_W-1:0]    stack_top;
	logic [LOW_W-1:0]   rd_hold_data;
	logic               rd_hold_zero;
	logic               rd_hold_ram;

	// ==========================================================
	// decode
	logic [DADDR_W-1:0] eff_addr;
	logic               is_indirect;
	logic               self_ref;
	logic [LOW_W-1:0]   target_reg;
	logic               any_pop;
	logic               any_push;
	logic               write_low;
	logic               write_latch;
	logic               write_ptr;
	logic               push_ret;
	pc_op_t             pc_op;
	logic [PC_W-1:0]    next_pc;
	logic [PC_W-1:0]    push_value;
	logic [AW-1:0]      next_stack_ptr;
	logic [AW-1:0]      rd_index;
	logic [LOW_W-1:0]   reg_rd_value;
	logic [LOW_W-1:0]   next_file_rd_data;

	function automatic logic hits(input logic [LOW_W-1:0] a,
	                              input logic [LOW_W-1:0] r);
		hits = ((a & ADDR_LOW_MASK) == r);
	endfunction

	indirect_addr_unit u_ind (
		.operand_addr      (operand_addr),
		.file_ptr          (file_pointer_reg),
		.indirect_bank_bit (indirect_bank_bit),
		.eff_addr          (eff_addr),
		.is_indirect       (is_indirect),
		.self_ref          (self_ref)
	);

	// core registers addressed either directly or through pointer
	assign target_reg  = eff_addr[LOW_W-1:0];
	assign write_low   = file_wr && !self_ref && hits(target_reg, PC_LOW_ADDR);
	assign write_latch = file_wr && !self_ref && hits(target_reg, LATCH_ADDR);
	assign write_ptr   = file_wr && !self_ref
	                     && hits(target_reg, FILE_PTR_ADDR);

	assign any_pop  = do_return || do_exit_literal || do_interrupt_exit;
	assign any_push = do_call || do_vector;

	// priority: vector, call, jump, return, low write, advance
	assign pc_op = do_vector ? PC_VECTOR :
	               (do_call || do_jump) ? PC_JUMP :
	               any_pop ? PC_RETURN :
	               write_low ? PC_WRLOW :
	               advance ? PC_NEXT : PC_HOLD;

	// call pushes the following instruction, also when vector wins; vector without call pushes pc itself
	assign push_ret   = do_call;
	assign push_value = push_ret ? pc + PC_STEP : pc;

	// ==========================================================
	// program counter next value
	always_comb begin
		unique case (pc_op)
			PC_NEXT:   next_pc = pc + PC_STEP;
			PC_HOLD:   next_pc = pc;
			PC_JUMP:   next_pc = {pc_high_holding_latch[HIGH_W-1:HIGH_W-PAGE_W],
			                      target_addr};
			PC_RETURN: next_pc = stack_top;
			PC_VECTOR: next_pc = VECTOR_ADDR;
			PC_WRLOW:  next_pc = {pc_high_holding_latch, file_wr_data};
			default:   next_pc = pc;
		endcase
	end

	// upper bits never written from data path directly
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pc <= PC_RESET;
		end else if (soft_reset) begin
			pc <= PC_RESET;
		end else begin
			pc <= next_pc;
		end
	end

	// ==========================================================
	// holding latch and file pointer
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pc_high_holding_latch <= LATCH_RESET;
		end else if (write_latch) begin
			// stack traffic never touches the latch
			pc_high_holding_latch <= file_wr_data[HIGH_W-1:0];
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			file_pointer_reg <= PTR_RESET;
		end else if (write_ptr) begin
			file_pointer_reg <= file_wr_data;
		end
	end

	// ==========================================================
	// return stack: pointer is internal only, wraps silently
	// stack_ptr addresses the next free slot
	assign next_stack_ptr = any_push ? stack_ptr + PTR_ONE :
	                        any_pop  ? stack_ptr - PTR_ONE : stack_ptr;
	// memory keeps the top entry in its read register
	assign rd_index = next_stack_ptr - PTR_ONE;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			stack_ptr <= '0;
		end else if (soft_reset) begin
			stack_ptr <= '0;
		end else begin
			stack_ptr <= next_stack_ptr;
		end
	end

	logic [PC_W-1:0] mem_rd;
	logic [PC_W-1:0] last_push;
	logic            bypass;

	return_stack_mem #(
		.DEPTH (DEPTH),
		.WIDTH (PC_W),
		.AW    (AW)
	) u_stack (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.wr_en   (any_push),
		.wr_addr (stack_ptr),
		.wr_data (push_value),
		.rd_addr (rd_index),
		.rd_data (mem_rd)
	);

	// a push makes the pushed value the new top at once
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			last_push <= PC_RESET;
			bypass    <= 1'b0;
		end else begin
			last_push <= push_value;
			bypass    <= any_push;
		end
	end
	assign stack_top = bypass ? last_push : mem_rd;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pop_valid   <= 1'b0;
		end else begin
			pop_valid   <= any_pop && !do_vector && !do_call;
		end
	end

	// ==========================================================
	// data memory access through redirect
	assign reg_rd_value = hits(target_reg, PC_LOW_ADDR) ? pc[LOW_W-1:0] :
	                      hits(target_reg, FILE_PTR_ADDR) ? file_pointer_reg :
	                      hits(target_reg, LATCH_ADDR)
	                        ? {{(LOW_W-HIGH_W){1'b0}}, pc_high_holding_latch}
	                        : ZERO_BYTE;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ram_wr      <= 1'b0;
			ram_rd      <= 1'b0;
			ram_addr    <= '0;
			ram_wr_data <= ZERO_BYTE;
		end else begin
			ram_wr      <= file_wr && !self_ref;
			ram_rd      <= file_rd && !self_ref;
			ram_addr    <= eff_addr;
			ram_wr_data <= file_wr_data;
		end
	end

	// read answer: zero for self reference, else core reg or ram
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_hold_data <= ZERO_BYTE;
			rd_hold_zero <= 1'b0;
			rd_hold_ram  <= 1'b0;
		end else begin
			rd_hold_data <= reg_rd_value;
			rd_hold_zero <= file_rd && self_ref;
			rd_hold_ram  <= file_rd && !self_ref
			                && !hits(target_reg, PC_LOW_ADDR)
			                && !hits(target_reg, FILE_PTR_ADDR)
			                && !hits(target_reg, LATCH_ADDR);
		end
	end

	assign next_file_rd_data = rd_hold_zero ? ZERO_BYTE :
	                           rd_hold_ram  ? ram_rd_data : rd_hold_data;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			file_rd_data <= ZERO_BYTE;
		end else begin
			file_rd_data <= next_file_rd_data;
		end
	end
endmodule

// *** data_ram_model.sv ***
// data memory model answering the block's memory strobes
`timescale 1ns/1ps
module data_ram_model
	import pc_stack_pkg::*;
(
	input  wire logic               sys_clk,
	input  wire logic               ram_wr,
	input  wire logic               ram_rd,
	input  wire logic [DADDR_W-1:0] ram_addr,
	input  wire logic [LOW_W-1:0]   ram_wr_data,
	output logic      [LOW_W-1:0]   ram_rd_data
);
	logic [LOW_W-1:0] mem [2**DADDR_W];
	logic [LOW_W-1:0] last;
	// released bus shows the inverse of the last value
	assign ram_rd_data = ram_rd ? mem[ram_addr] : ~last;
	always_ff @(posedge sys_clk) begin
		if (ram_wr)
			mem[ram_addr] <= ram_wr_data;
		if (ram_rd)
			last <= mem[ram_addr];
	end
endmodule

// *** pc_stack_sva.sv ***
// concurrent checks on program counter, stack and indirect access
`timescale 1ns/1ps
module pc_stack_sva
	import pc_stack_pkg::*;
#(
	parameter logic [PC_W-1:0] VECTOR_ADDR = 13'h0004
) (
	input wire logic               sys_clk,
	input wire logic               arst_n,
	input wire logic               soft_reset,
	input wire logic               do_call,
	input wire logic               do_jump,
	input wire logic               do_return,
	input wire logic               do_exit_literal,
	input wire logic               do_interrupt_exit,
	input wire logic               do_vector,
	input wire logic [JUMP_W-1:0]  target_addr,
	input wire logic               file_wr,
	input wire logic               file_rd,
	input wire logic [LOW_W-1:0]   operand_addr,
	input wire logic [LOW_W-1:0]   file_wr_data,
	input wire logic [PC_W-1:0]    pc,
	input wire logic [LOW_W-1:0]   file_rd_data,
	input wire logic               ram_wr,
	input wire logic               ram_rd,
	input wire logic [DADDR_W-1:0] ram_addr
);
	logic [HIGH_W-1:0] seen_latch;
	logic [LOW_W-1:0]  seen_ptr;
	wire               pop_any = do_return | do_exit_literal
	                             | do_interrupt_exit;
	wire               busy = do_vector | do_call | do_jump | soft_reset;
	wire [LOW_W-1:0]   a = operand_addr & ADDR_LOW_MASK;
	wire               self = a == INDIRECT_ADDR && seen_ptr == INDIRECT_ADDR;
	// ==========================================
	// shadow of latch and pointer from direct writes
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			seen_latch <= LATCH_RESET;
			seen_ptr <= PTR_RESET;
		end else if (file_wr) begin
			if (a == LATCH_ADDR)
				seen_latch <= file_wr_data[HIGH_W-1:0];
			if (a == FILE_PTR_ADDR)
				seen_ptr <= file_wr_data;
		end
	end
	// ==========================================
	// properties
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	sequence s_call;
		do_call && !do_vector && !soft_reset;
	endsequence
	sequence s_pop;
		pop_any && !busy;
	endsequence
	reset_clear_a:
		assert property (soft_reset |=> pc == PC_RESET)
		else $error("pc not cleared by soft reset");
	low_write_a:
		assert property (file_wr && a == PC_LOW_ADDR && !busy && !pop_any
			|=> pc == {$past(seen_latch), $past(file_wr_data)})
		else $error("pc wrong after low byte write");
	jump_load_a:
		assert property ((do_jump || do_call) && !do_vector && !soft_reset
			|=> pc == {$past(seen_latch[4:3]), $past(target_addr)})
		else $error("pc wrong after call or jump");
	vector_load_a:
		assert property (do_vector && !soft_reset |=> pc == VECTOR_ADDR)
		else $error("pc wrong after vector");
	call_return_a:
		assert property (s_call ##1 s_pop |=> pc == $past(pc, 2) + PC_STEP)
		else $error("return did not restore call address");
	self_read_a:
		assert property (file_rd && self |=> !ram_rd ##1 file_rd_data == 8'h00)
		else $error("self indirect read not zero");
	self_write_a:
		assert property (file_wr && self |=> !ram_wr)
		else $error("self indirect write reached memory");
	indirect_addr_a:
		assert property ((file_wr || file_rd) && a == INDIRECT_ADDR
			&& seen_ptr[7:4] != 4'h0
			|=> (ram_wr || ram_rd) && ram_addr == {1'b0, $past(seen_ptr)})
		else $error("indirect address wrong");
endmodule

bind pc_stack_indirect_addr pc_stack_sva #(.VECTOR_ADDR(VECTOR_ADDR)) chk (
	.sys_clk(sys_clk), .arst_n(arst_n), .soft_reset(soft_reset),
	.do_call(do_call), .do_jump(do_jump), .do_return(do_return),
	.do_exit_literal(do_exit_literal), .do_vector(do_vector),
	.do_interrupt_exit(do_interrupt_exit), .target_addr(target_addr),
	.file_wr(file_wr), .file_rd(file_rd), .operand_addr(operand_addr),
	.file_wr_data(file_wr_data), .pc(pc), .file_rd_data(file_rd_data),
	.ram_wr(ram_wr), .ram_rd(ram_rd), .ram_addr(ram_addr)
);

// *** testbench.sv ***
// self-checking bench for program counter, stack and indirect access
`timescale 1ns/1ps
module testbench
	import pc_stack_pkg::*;
;
	localparam logic [7:0] ADV = 8'h01, SRST = 8'h02, IEX = 8'h04;
	localparam logic [7:0] LIT = 8'h08, RET = 8'h10, JMP = 8'h20;
	localparam logic [7:0] CALL = 8'h40, VEC = 8'h80;
	localparam logic [PC_W-1:0] VEC_AT = 13'h0104;
	logic sys_clk = 1'b0, arst_n = 1'b0, soft_reset = 1'b0, advance = 1'b0;
	logic do_call = 1'b0, do_jump = 1'b0, do_return = 1'b0, do_vector = 1'b0;
	logic do_exit_literal = 1'b0, do_interrupt_exit = 1'b0;
	logic file_wr = 1'b0, file_rd = 1'b0;
	logic [JUMP_W-1:0] target_addr = 11'h000;
	logic [LOW_W-1:0]  operand_addr = 8'h00, file_wr_data = 8'h00;
	wire [LOW_W-1:0]   ram_rd_data, file_rd_data, ram_wr_data;
	wire [DADDR_W-1:0] ram_addr;
	wire [PC_W-1:0]    pc;
	wire               ram_wr, ram_rd, pop_valid;
	int                err_count = 0, checked = 0;

	pc_stack_indirect_addr #(.VECTOR_ADDR(VEC_AT)) dut (
		.sys_clk(sys_clk), .arst_n(arst_n), .soft_reset(soft_reset),
		.advance(advance), .do_call(do_call), .do_jump(do_jump),
		.do_return(do_return), .do_exit_literal(do_exit_literal),
		.do_interrupt_exit(do_interrupt_exit), .do_vector(do_vector),
		.target_addr(target_addr), .file_wr(file_wr), .file_rd(file_rd),
		.operand_addr(operand_addr), .file_wr_data(file_wr_data),
		.ram_rd_data(ram_rd_data), .indirect_bank_bit(1'b0),
		.pc(pc), .file_rd_data(file_rd_data), .ram_wr(ram_wr),
		.ram_rd(ram_rd), .ram_addr(ram_addr), .ram_wr_data(ram_wr_data),
		.pop_valid(pop_valid)
	);
	data_ram_model ram (
		.sys_clk(sys_clk), .ram_wr(ram_wr), .ram_rd(ram_rd),
		.ram_addr(ram_addr), .ram_wr_data(ram_wr_data),
		.ram_rd_data(ram_rd_data)
	);
	// ==========================================
	// drivers and comparison
	task automatic step;
		@(posedge sys_clk);
		#2;
	endtask
	task automatic ctl(input logic [7:0] s);
		{do_vector, do_call, do_jump, do_return, do_exit_literal,
			do_interrupt_exit, soft_reset, advance} = s;
		step;
	endtask
	task automatic acc(input logic w, r, input logic [7:0] ad, d);
		file_wr = w;
		file_rd = r;
		operand_addr = ad;
		file_wr_data = d;
		step;
	endtask
	task automatic check(input string what, input logic [15:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic pc_is(input logic [PC_W-1:0] e);
		check("pc", {3'h0, pc}, {3'h0, e});
	endtask
	task automatic wr(input logic [7:0] ad, d);
		ctl(8'h00);
		acc(1'b1, 1'b0, ad, d);
		acc(1'b0, 1'b0, ad, d);
	endtask
	task automatic rd(input logic [7:0] ad, e);
		ctl(8'h00);
		acc(1'b0, 1'b1, ad, 8'h00);
		acc(1'b0, 1'b0, ad, 8'h00);
		check("file_rd_data", {8'h00, file_rd_data}, {8'h00, e});
	endtask
	// ==========================================
	// scenarios
	task automatic t_reset;
		pc_is(PC_RESET);
		repeat (3) ctl(ADV);
		pc_is(13'h0003);
		ctl(SRST);
		pc_is(PC_RESET);
		$display("test reset done");
	endtask
	task automatic t_low;
		wr(LATCH_ADDR, 8'hf5);
		wr(PC_LOW_ADDR, 8'h7c);
		pc_is(13'h157c);
		wr(LATCH_ADDR, 8'h00);
		pc_is(13'h157c);
		$display("test low write done");
	endtask
	task automatic t_flow;
		logic [PC_W-1:0] p;
		logic [7:0] pops [3] = '{RET, LIT, IEX};
		wr(LATCH_ADDR, 8'h1f);
		target_addr = 11'h123;
		ctl(JMP);
		pc_is(13'h1923);
		for (int i = 0; i < 3; i++) begin
			p = pc;
			target_addr = 11'h040 + 11'(i);
			ctl(CALL);
			pc_is({2'b11, target_addr});
			ctl(pops[i]);
			check("pop_valid", {15'h0000, pop_valid}, 16'h0001);
			pc_is(p + PC_STEP);
		end
		p = pc;
		ctl(VEC);
		pc_is(VEC_AT);
		check("pop_valid", {15'h0000, pop_valid}, 16'h0000);
		ctl(IEX);
		pc_is(p);
		wr(PC_LOW_ADDR, 8'h00);
		pc_is(13'h1f00);
		$display("test flow done");
	endtask
	task automatic t_wrap;
		wr(LATCH_ADDR, 8'h00);
		for (int i = 0; i < 9; i++) begin
			target_addr = 11'h100 + 11'(8 * i);
			ctl(CALL);
		end
		for (int k = 0; k < 9; k++) begin
			ctl(RET);
			pc_is(13'h0101 + 13'(8 * ((15 - k) % 8)));
		end
		$display("test wrap done");
	endtask
	task automatic t_ind;
		wr(FILE_PTR_ADDR, 8'h30);
		ctl(8'h00);
		acc(1'b1, 1'b0, INDIRECT_ADDR, 8'ha5);
		check("ram_wr", {15'h0000, ram_wr}, 16'h0001);
		check("ram_addr", {7'h00, ram_addr}, 16'h0030);
		acc(1'b0, 1'b0, INDIRECT_ADDR, 8'h00);
		rd(INDIRECT_ADDR, 8'ha5);
		rd(8'h30, 8'ha5);
		wr(FILE_PTR_ADDR, INDIRECT_ADDR);
		rd(INDIRECT_ADDR, ZERO_BYTE);
		ctl(8'h00);
		acc(1'b1, 1'b0, INDIRECT_ADDR, 8'h5a);
		check("ram_wr", {15'h0000, ram_wr}, 16'h0000);
		acc(1'b0, 1'b0, INDIRECT_ADDR, 8'h00);
		$display("test indirect done");
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ==========================================
	// clock, sequence and watchdog
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (4) @(posedge sys_clk);
		#2;
		arst_n = 1'b1;
		t_reset;
		t_low;
		t_flow;
		t_wrap;
		t_ind;
		close_out;
	end
	initial begin
		#100000;
		err_count++;
		close_out;
	end
endmodule
